/* src/ctt_pkg.sv */
/*
 * Constants and carrier types for the compare timer with trigger start.
 * Assumes a single 100 MHz clock that also serves as the main clock.
 */
package ctt_pkg;

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [7:0] CTT_OFF_CTRL = 8'h00;
    localparam logic [7:0] CTT_OFF_PER_LO = 8'h04;
    localparam logic [7:0] CTT_OFF_PER_HI = 8'h08;
    localparam logic [7:0] CTT_OFF_CAPTURE = 8'h0c;
    localparam logic [7:0] CTT_OFF_STATUS = 8'h10;
    localparam logic [7:0] CTT_OFF_INT_CLR = 8'h14;
    localparam logic [7:0] CTT_OFF_INT_EN = 8'h18;
    localparam logic [7:0] CTT_OFF_COUNT = 8'h1c;

    // ************************************************************
    // Control register fields.
    // ************************************************************
    localparam int CTT_CTRL_SRC_LSB = 2;
    localparam int CTT_CTRL_START_LSB = 4;
    localparam int CTT_CTRL_BIT6 = 6;
    localparam logic [1:0] CTT_START_STOP = 2'h0;
    localparam logic [1:0] CTT_START_RUN = 2'h1;
    localparam logic [1:0] CTT_START_TRIG = 2'h3;
    localparam logic [1:0] CTT_SRC_SLOW = 2'h0;
    localparam logic [1:0] CTT_SRC_MID = 2'h1;
    localparam logic [1:0] CTT_SRC_FAST = 2'h2;

    // ************************************************************
    // Status bits and reset values.
    // ************************************************************
    localparam int CTT_ST_MATCH = 0;
    localparam int CTT_ST_RUNNING = 1;
    localparam int CTT_ST_WAITING = 2;
    localparam logic [15:0] CTT_PERIOD_RST = 16'hffff;

    // ************************************************************
    // Prescaler taps of the main clock and sub clock divider.
    // ************************************************************
    localparam int CTT_TAP_SLOW = 11;
    localparam int CTT_TAP_MID = 7;
    localparam int CTT_TAP_FAST = 3;
    localparam int CTT_SUB_DIV_BITS = 3;

    // ************************************************************
    // Trigger filter, in main clock periods.
    // ************************************************************
    localparam int CTT_FLT_REJECT_FC = 7;
    localparam int CTT_FLT_ACCEPT_FC = 24;
    localparam logic [4:0] CTT_FLT_CYCLES =
        5'((CTT_FLT_REJECT_FC + CTT_FLT_ACCEPT_FC + 1) / 2);

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic hready;
        logic [31:0] hwdata;
    } ctt_ahb_req_t;

    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } ctt_ahb_rsp_t;

    typedef enum logic [1:0] {
        CTT_IDLE,
        CTT_WAIT,
        CTT_COUNT
    } ctt_state_t;

endpackage

/* src/ctt_timer.sv */
/*
 * Sixteen bit compare timer with software capture and an optional start
 * from a trigger pin that is filtered outside slow mode, reached as an AHB-Lite slave.
 * Assumes all pin inputs are synchronous to i_ref_clk and that the edge
 * polarity, divider tap and slow mode levels come from system logic.
 */
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

module ctt_timer
    import ctt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire ctt_ahb_req_t i_ahb,
    output ctt_ahb_rsp_t o_ahb,
    input wire logic i_trigger_input_pin,
    input wire logic i_sub_clock,
    input wire logic i_edge_polarity_select,
    input wire logic i_divider_tap_select,
    input wire logic i_slow_mode,
    output logic o_timer_match_irq
);

    // ************************************************************
    // Bus address phase capture.
    // ************************************************************
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [31:0] rdata_ff;
    logic addr_phase;
    logic wr_now;
    logic [31:0] wdata;

    assign addr_phase = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1];
    assign wr_now = wr_pend_ff;
    assign wdata = i_ahb.hwdata;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else if (i_ahb.hready)
        begin
            wr_pend_ff <= addr_phase && i_ahb.hwrite;
            wr_addr_ff <= i_ahb.haddr[7:0];
        end
    end

    // ************************************************************
    // Control, period and interrupt registers.
    // ************************************************************
    logic [1:0] start_ff;
    logic [1:0] src_ff;
    logic stop_bit_ff;
    logic [7:0] per_lo_stage_ff;
    logic [15:0] period_ff;
    logic [15:0] capture_ff;
    logic match_st_ff;
    logic match_en_ff;
    logic ctrl_wr;
    logic capture_req;
    logic match_evt;

    assign ctrl_wr = wr_now && (wr_addr_ff == CTT_OFF_CTRL);
    // The capture bit is also stored as the stop bit, but the control register always reads back as zero.
    assign capture_req = ctrl_wr && wdata[CTT_CTRL_BIT6]
                         && (wdata[CTT_CTRL_START_LSB +: 2] != CTT_START_TRIG);

    // Only whole writes exist on this port, matching a write-only register.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            start_ff <= CTT_START_STOP;
            src_ff <= CTT_SRC_SLOW;
            stop_bit_ff <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            start_ff <= wdata[CTT_CTRL_START_LSB +: 2];
            src_ff <= wdata[CTT_CTRL_SRC_LSB +: 2];
            stop_bit_ff <= wdata[CTT_CTRL_BIT6];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            per_lo_stage_ff <= CTT_PERIOD_RST[7:0];
            period_ff <= CTT_PERIOD_RST;
        end
        else if (wr_now && wr_addr_ff == CTT_OFF_PER_LO)
        begin
            per_lo_stage_ff <= wdata[7:0];
        end
        else if (wr_now && wr_addr_ff == CTT_OFF_PER_HI)
        begin
            period_ff <= {wdata[7:0], per_lo_stage_ff};
        end
    end

    // A match in the same cycle as a clear write keeps the flag set.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            match_st_ff <= 1'b0;
        end
        else if (match_evt)
        begin
            match_st_ff <= 1'b1;
        end
        else if (wr_now && wr_addr_ff == CTT_OFF_INT_CLR
                 && wdata[CTT_ST_MATCH])
        begin
            match_st_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            match_en_ff <= 1'b0;
        end
        else if (wr_now && wr_addr_ff == CTT_OFF_INT_EN)
        begin
            match_en_ff <= wdata[CTT_ST_MATCH];
        end
    end

    assign o_timer_match_irq = match_st_ff && match_en_ff;

    // ************************************************************
    // Prescaler and source clock selection.
    // ************************************************************
    logic [CTT_TAP_SLOW-1:0] presc_ff;
    logic [CTT_SUB_DIV_BITS-1:0] sub_div_ff;
    logic sub_prev_ff;
    logic sub_rise;
    logic sub_tick;
    logic tick;

    assign sub_rise = i_sub_clock && !sub_prev_ff;
    assign sub_tick = sub_rise && (&sub_div_ff);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            presc_ff <= '0;
            sub_div_ff <= '0;
            sub_prev_ff <= 1'b0;
        end
        else
        begin
            presc_ff <= presc_ff + 1'b1;
            sub_prev_ff <= i_sub_clock;
            if (sub_rise)
            begin
                sub_div_ff <= sub_div_ff + 1'b1;
            end
        end
    end

    // In slow mode the main clock taps are not used, so only the sub clock
    // divided by eight remains, whatever the source field says.
    always_comb
    begin
        tick = 1'b0;
        if (i_slow_mode)
        begin
            tick = sub_tick;
        end
        else
        begin
            unique case (src_ff)
                CTT_SRC_SLOW:
                    tick = i_divider_tap_select ? sub_tick
                                                : (&presc_ff);
                CTT_SRC_MID:
                    tick = &presc_ff[CTT_TAP_MID-1:0];
                CTT_SRC_FAST:
                    tick = &presc_ff[CTT_TAP_FAST-1:0];
                default:
                    tick = 1'b0;
            endcase
        end
    end

    // ************************************************************
    // Trigger pin noise filter and edge detection.
    // ************************************************************
    logic flt_level_ff;
    logic [4:0] flt_cnt_ff;
    logic trig_prev_ff;
    logic trig_level;
    logic trig_rise;
    logic trig_fall;
    logic start_edge;
    logic opp_edge;

    // The level is accepted after standing for a count between the reject
    // and accept widths, which leaves margin on both sides.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            flt_level_ff <= 1'b0;
            flt_cnt_ff <= 5'h00;
        end
        else if (i_trigger_input_pin == flt_level_ff)
        begin
            flt_cnt_ff <= 5'h00;
        end
        else if (flt_cnt_ff == CTT_FLT_CYCLES - 5'h01)
        begin
            flt_level_ff <= i_trigger_input_pin;
            flt_cnt_ff <= 5'h00;
        end
        else
        begin
            flt_cnt_ff <= flt_cnt_ff + 5'h01;
        end
    end

    assign trig_level = i_slow_mode ? i_trigger_input_pin
                                    : flt_level_ff;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            trig_prev_ff <= 1'b0;
        end
        else
        begin
            trig_prev_ff <= trig_level;
        end
    end

    assign trig_rise = trig_level && !trig_prev_ff;
    assign trig_fall = !trig_level && trig_prev_ff;
    // Polarity zero starts on a rising edge, one on a falling edge.
    assign start_edge = i_edge_polarity_select ? trig_fall
                                               : trig_rise;
    assign opp_edge = i_edge_polarity_select ? trig_rise : trig_fall;

    // ************************************************************
    // Counter state machine.
    // ************************************************************
    ctt_state_t state_ff;
    logic [15:0] cnt_ff;
    logic [15:0] cnt_inc;
    logic trig_mode;

    assign cnt_inc = cnt_ff + 16'h0001;
    assign trig_mode = (start_ff == CTT_START_TRIG);
    assign match_evt = (state_ff == CTT_COUNT) && tick
                       && (cnt_inc == period_ff);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            state_ff <= CTT_IDLE;
            cnt_ff <= 16'h0000;
        end
        else
        begin
            unique case (state_ff)
                CTT_IDLE:
                begin
                    cnt_ff <= 16'h0000;
                    if (start_ff == CTT_START_RUN)
                    begin
                        state_ff <= CTT_COUNT;
                    end
                    else if (trig_mode)
                    begin
                        state_ff <= CTT_WAIT;
                    end
                end
                CTT_WAIT:
                begin
                    cnt_ff <= 16'h0000;
                    if (start_ff == CTT_START_STOP)
                    begin
                        state_ff <= CTT_IDLE;
                    end
                    else if (!trig_mode || start_edge)
                    begin
                        state_ff <= CTT_COUNT;
                    end
                end
                CTT_COUNT:
                begin
                    // Start edges while counting fall through unused.
                    if (start_ff == CTT_START_STOP)
                    begin
                        state_ff <= CTT_IDLE;
                        cnt_ff <= 16'h0000;
                    end
                    else if (trig_mode && stop_bit_ff && opp_edge)
                    begin
                        state_ff <= CTT_WAIT;
                        cnt_ff <= 16'h0000;
                    end
                    else if (match_evt)
                    begin
                        cnt_ff <= 16'h0000;
                        if (trig_mode)
                        begin
                            state_ff <= CTT_WAIT;
                        end
                    end
                    else if (tick)
                    begin
                        cnt_ff <= cnt_inc;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            capture_ff <= 16'h0000;
        end
        else if (capture_req)
        begin
            capture_ff <= cnt_ff;
        end
    end

    // ************************************************************
    // Read data, taken in the address phase and held for the data phase.
    // ************************************************************
    logic [31:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        unique case (i_ahb.haddr[7:0])
            CTT_OFF_PER_LO:
                nxt_rdata = {24'h00_0000, period_ff[7:0]};
            CTT_OFF_PER_HI:
                nxt_rdata = {24'h00_0000, period_ff[15:8]};
            CTT_OFF_CAPTURE:
                nxt_rdata = {16'h0000, capture_ff};
            CTT_OFF_STATUS:
                nxt_rdata = {29'h0000_0000,
                             state_ff == CTT_WAIT,
                             state_ff == CTT_COUNT,
                             match_st_ff};
            CTT_OFF_INT_EN:
                nxt_rdata = {31'h0000_0000, match_en_ff};
            CTT_OFF_COUNT:
                nxt_rdata = {16'h0000, cnt_ff};
            default:
                nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else if (addr_phase && !i_ahb.hwrite)
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // The slave never stalls and never signals an error.
    assign o_ahb.hrdata = rdata_ff;
    assign o_ahb.hreadyout = 1'b1;
    assign o_ahb.hresp = 1'b0;

endmodule

/* testbench/ctt_timer_monitor.sv */
/*
 * Concurrent checks on the ports of the compare timer.
 * Assumes single word AHB-Lite transfers and one clock domain.
 */
`timescale 1ns/1ps
module ctt_timer_monitor
    import ctt_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire ctt_ahb_req_t i_ahb,
    input wire ctt_ahb_rsp_t o_ahb,
    input wire logic i_trigger_input_pin,
    input wire logic o_timer_match_irq
);
    logic take;
    logic rd_take;
    logic wr_dp_ff;
    logic [7:0] wa_ff;
    logic en_ff;

    assign take = i_ahb.hsel & i_ahb.hready & i_ahb.htrans[1];
    assign rd_take = take & ~i_ahb.hwrite;

    // Shadow of the enable bit, so the interrupt can be tied to it.
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            wr_dp_ff <= 1'b0;
            wa_ff <= 8'h00;
        end
        else
        begin
            wr_dp_ff <= take & i_ahb.hwrite;
            wa_ff <= i_ahb.haddr[7:0];
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            en_ff <= 1'b0;
        else if (wr_dp_ff && wa_ff == CTT_OFF_INT_EN)
            en_ff <= i_ahb.hwdata[0];
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ************************************************************
    // Assertions.
    // ************************************************************
    a_bus_okay: assert property (
        o_ahb.hreadyout && !o_ahb.hresp)
        else $error("slave stalled or answered with an error");
    a_irq_reset_low: assert property (disable iff (1'b0)
        !i_rst_n |=> !o_timer_match_irq)
        else $error("interrupt high after a reset cycle");
    a_ctrl_reads_zero: assert property (
        rd_take && i_ahb.haddr[7:0] == CTT_OFF_CTRL |=> o_ahb.hrdata == 32'h0)
        else $error("control register is readable");
    a_clr_reads_zero: assert property (
        rd_take && i_ahb.haddr[7:0] == CTT_OFF_INT_CLR
        |=> o_ahb.hrdata == 32'h0)
        else $error("clear register is readable");
    a_unmapped_zero: assert property (
        rd_take && i_ahb.haddr[7:0] > CTT_OFF_COUNT |=> o_ahb.hrdata == 32'h0)
        else $error("unmapped read returned data");
    a_rdata_stands: assert property (
        !rd_take |=> $stable(o_ahb.hrdata))
        else $error("read data changed without a read");
    a_irq_needs_en: assert property (
        o_timer_match_irq |-> en_ff)
        else $error("interrupt high while disabled");
    a_irq_falls_on_write: assert property (
        $fell(o_timer_match_irq) |-> $past(wr_dp_ff) &&
        ($past(wa_ff) == CTT_OFF_INT_CLR || $past(wa_ff) == CTT_OFF_INT_EN))
        else $error("interrupt dropped without a clear or mask");

    c_irq_rise: cover property ($rose(o_timer_match_irq));
    c_capture_read: cover property (
        rd_take && i_ahb.haddr[7:0] == CTT_OFF_CAPTURE);
    c_pin_fall: cover property ($fell(i_trigger_input_pin));
endmodule

/* testbench/ctt_pulse_src.sv */
/*
 * Pulse source that drives the trigger pin of the compare timer.
 * Assumes it is clocked by the timer's own clock; changes follow its edges.
 */
`timescale 1ns/1ps
module ctt_pulse_src (
    input wire logic i_clk,
    output logic o_pin
);
    initial o_pin = 1'b0;

    task automatic set_level(input logic lvl);
        @(posedge i_clk);
        o_pin <= lvl;
    endtask

    // Every level, the return to idle too, is held w clocks, so a caller
    // that asks for short pulses is the only source of filter rejects.
    task automatic train(input int w, input int n);
        repeat (2 * n)
        begin
            @(posedge i_clk);
            o_pin <= ~o_pin;
            repeat (w - 1) @(posedge i_clk);
        end
    endtask
endmodule

/* testbench/testbench.sv */
/*
 * Self-checking bench for the compare timer: bus reads are queued and
 * compared by a watcher; interrupt timing is compared directly.
 * Assumes the package offsets and a free running prescaler.
 */
`timescale 1ns/1ps
module testbench
    import ctt_pkg::*;
;
    localparam int SUBP = 10;
    localparam logic [31:0] ST_WAIT = 32'h1 << CTT_ST_WAITING;
    localparam logic [31:0] ST_MATCH = 32'h1 << CTT_ST_MATCH;
    logic clk, rst_n, pin, sub_clk, pol, div, slow, irq, rd_dp;
    ctt_ahb_req_t req;
    ctt_ahb_rsp_t rsp;
    int cyc, failures, n_checks;
    logic [63:0] expq[$];
    logic [63:0] e;
    logic [7:0] rst_addr [8] = '{CTT_OFF_CTRL, CTT_OFF_CAPTURE,
        CTT_OFF_STATUS, CTT_OFF_INT_CLR, CTT_OFF_INT_EN, CTT_OFF_COUNT,
        8'h20, 8'h7c};
    logic [1:0] tsrc [5] = '{CTT_SRC_FAST, CTT_SRC_MID, CTT_SRC_SLOW,
        CTT_SRC_SLOW, CTT_SRC_FAST};
    logic tdiv [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic tslow [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    int tclk [5] = '{1 << CTT_TAP_FAST, 1 << CTT_TAP_MID, 1 << CTT_TAP_SLOW,
        SUBP << CTT_SUB_DIV_BITS, SUBP << CTT_SUB_DIV_BITS};

    ctt_timer uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ahb(req),
        .o_ahb(rsp), .i_trigger_input_pin(pin), .i_sub_clock(sub_clk),
        .i_edge_polarity_select(pol), .i_divider_tap_select(div),
        .i_slow_mode(slow), .o_timer_match_irq(irq));
    ctt_pulse_src src (.i_clk(clk), .o_pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge clk) sub_clk <= (cyc % SUBP) < (SUBP / 2);

    // ************************************************************
    // Checking.
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic chk_rng(input int v, input int lo, input int hi);
        chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask
    always @(posedge clk)
    begin
        if (rd_dp)
        begin
            e = expq.pop_front();
            chk(rsp.hrdata & e[63:32], e[31:0]);
        end
        rd_dp <= req.hsel & req.htrans[1] & ~req.hwrite & req.hready & rst_n;
    end
    task automatic finish_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************************
    // Bus and timing tasks.
    // ************************************************************
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        req <= '{hsel:1'b1, haddr:{24'h0, a}, htrans:2'h2, hwrite:w,
            hsize:3'h2, hready:rsp.hreadyout, hwdata:req.hwdata};
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
        req <= '{hsel:1'b0, haddr:req.haddr, htrans:2'h0, hwrite:1'b0,
            hsize:3'h2, hready:rsp.hreadyout, hwdata:d};
        do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic [31:0] m = 32'hffffffff);
        expq.push_back({m, x});
        bus(a, 1'b0, 32'h0);
    endtask
    function automatic logic [31:0] cw(input logic b6, input logic [1:0] st,
        input logic [1:0] sr);
        return (32'(b6) << CTT_CTRL_BIT6) | (32'(st) << CTT_CTRL_START_LSB) |
            (32'(sr) << CTT_CTRL_SRC_LSB);
    endfunction
    task automatic chk_irq(input logic x);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, x});
    endtask
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (irq !== 1'b1 && n < 20000);
        if (n >= 20000)
            chk(32'h0, 32'h1);
        t = cyc;
    endtask
    // Clears first so that both rises are fresh matches, not a stale flag.
    task automatic meas(input int exp);
        int t0;
        int t1;
        wr(CTT_OFF_INT_CLR, 32'h1);
        wait_irq(t0);
        wr(CTT_OFF_INT_CLR, 32'h1);
        wait_irq(t1);
        chk_rng(t1 - t0, exp, exp);
    endtask
    task automatic trig(input int w, input int n, input int lo, input int hi);
        int ts;
        int t;
        ts = cyc;
        fork
            src.train(w, n);
        join_none
        wait_irq(t);
        chk_rng(t - ts, lo, hi);
        wait fork;
        wr(CTT_OFF_INT_CLR, 32'h1);
    endtask
    task automatic period(input logic [15:0] p);
        wr(CTT_OFF_PER_LO, {24'h0, p[7:0]});
        wr(CTT_OFF_PER_HI, {24'h0, p[15:8]});
    endtask

    // ************************************************************
    // Scenarios.
    // ************************************************************
    initial
    begin
        req = '{hsel:1'b0, haddr:32'h0, htrans:2'h0, hwrite:1'b0,
            hsize:3'h2, hready:1'b1, hwdata:32'h0};
        rst_n = 1'b0;
        pol = 1'b0;
        div = 1'b0;
        slow = 1'b0;
        cyc = 0;
        failures = 0;
        n_checks = 0;
        rd_dp = 1'b0;
        sub_clk = 1'b0;
        void'($urandom(32'h5276a87f));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rst_addr[i]) rd(rst_addr[i], 32'h0);
        rd(CTT_OFF_PER_LO, 32'hff);
        rd(CTT_OFF_PER_HI, 32'hff);
        wr(CTT_OFF_INT_EN, 32'h1);
        period(16'h0003);
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_RUN, CTT_SRC_FAST));
        meas(3 << CTT_TAP_FAST);
        rd(CTT_OFF_STATUS, 32'h2, 32'h6);
        wr(CTT_OFF_PER_LO, 32'($urandom % 200) + 32'd20);
        meas(3 << CTT_TAP_FAST);
        period(16'h0005);
        meas(5 << CTT_TAP_FAST);
        // Stop first: a period below the running count would only match
        // after the counter wraps.
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_STOP, CTT_SRC_FAST));
        period(16'h0002);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk);
            div <= tdiv[i];
            slow <= tslow[i];
            wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_RUN, tsrc[i]));
            meas(2 * tclk[i]);
        end
        @(posedge clk);
        div <= 1'b0;
        slow <= 1'b0;
        period(16'h0010);
        wr(CTT_OFF_INT_CLR, 32'h1);
        wait_irq(cyc);
        repeat (8) @(posedge clk);
        wr(CTT_OFF_CTRL, cw(1'b1, CTT_START_RUN, CTT_SRC_FAST));
        rd(CTT_OFF_CAPTURE, 32'h1);
        repeat (40) @(posedge clk);
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_RUN, CTT_SRC_FAST));
        rd(CTT_OFF_CAPTURE, 32'h1);
        wr(CTT_OFF_INT_EN, 32'h0);
        repeat (200) @(posedge clk);
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_STOP, CTT_SRC_FAST));
        rd(CTT_OFF_STATUS, ST_MATCH);
        chk_irq(1'b0);
        wr(CTT_OFF_INT_EN, 32'h1);
        chk_irq(1'b1);
        wr(CTT_OFF_INT_CLR, 32'h1);
        chk_irq(1'b0);
        period(16'h0004);
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_TRIG, CTT_SRC_FAST));
        repeat (100) @(posedge clk);
        rd(CTT_OFF_STATUS, ST_WAIT);
        trig(24, 1, 38, 56);
        repeat (100) @(posedge clk);
        rd(CTT_OFF_STATUS, ST_WAIT);
        rd(CTT_OFF_COUNT, 32'h0);
        src.train(1 + int'($urandom % 7), 1);
        repeat (60) @(posedge clk);
        rd(CTT_OFF_STATUS, ST_WAIT);
        period(16'h0020);
        trig(30, 2, 260, 280);
        wr(CTT_OFF_CTRL, cw(1'b1, CTT_START_TRIG, CTT_SRC_FAST));
        src.train(40, 1);
        repeat (300) @(posedge clk);
        rd(CTT_OFF_STATUS, ST_WAIT);
        chk_irq(1'b0);
        trig(300, 1, 260, 280);
        wr(CTT_OFF_CTRL, cw(1'b0, CTT_START_TRIG, CTT_SRC_FAST));
        period(16'h0002);
        @(posedge clk);
        slow <= 1'b1;
        pol <= 1'b1;
        src.set_level(1'b1);
        repeat (20) @(posedge clk);
        rd(CTT_OFF_STATUS, ST_WAIT);
        trig(4, 1, 80, 170);
        finish_test();
    end

    initial
    begin
        repeat (80000) @(posedge clk);
        failures++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        finish_test();
    end
endmodule

bind ctt_timer ctt_timer_monitor mon (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_ahb(i_ahb), .o_ahb(o_ahb),
    .i_trigger_input_pin(i_trigger_input_pin),
    .o_timer_match_irq(o_timer_match_irq));
